// ---- src/aldp_pkg.sv ----
// Package for the add and logic datapath: field positions, widths, encodings.
// Assumes big-endian bit numbering of the instruction word (bit 0 is the MSB).
package aldp_pkg;

    // ------------------------------------------------------------------
    // Word and field geometry
    // ------------------------------------------------------------------
    localparam int DATA_W      = 32;
    localparam int REG_IDX_W   = 5;
    localparam int LIT_W       = 16;
    localparam int OPC_W       = 6;
    // Field boundaries counted from bit 0 at the MSB end.
    localparam int POS_DST     = 6;
    localparam int POS_SRC_A   = 11;
    localparam int POS_SRC_B   = 16;
    // Option bits counted from bit 0 at the MSB end.
    localparam int POS_HOLD    = 3;
    localparam int POS_CIN     = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic        RST_CARRY   = 1'b0;
    localparam logic [15:0] RST_UPPER   = 16'h0000;

    // ------------------------------------------------------------------
    // Operation classes, taken from opcode bits 0..1 and 5 (bits 2..4 are
    // the format bit and the option bits).
    // ------------------------------------------------------------------
    localparam logic [1:0] OPC_CLASS_ADD   = 2'h0;
    localparam logic [1:0] OPC_CLASS_LOGIC = 2'h2;
    localparam logic [3:0] OPC_AND         = 4'h1;
    localparam logic [3:0] OPC_ANDN        = 4'h3;
    localparam logic [5:0] OPC_UPPER_LIT   = 6'h2C;

    typedef enum logic [2:0]
    {
        ALDP_OP_NONE  = 3'h0,
        ALDP_OP_ADD   = 3'h1,
        ALDP_OP_AND   = 3'h2,
        ALDP_OP_ANDN  = 3'h3,
        ALDP_OP_UPPER = 3'h4
    } aldp_op_t;

endpackage : aldp_pkg

// ---- src/aldp_dec_if.sv ----
// Interface carrying decoded instruction fields between decoder and datapath.
// Assumes a single clock domain; no timing of its own.
`timescale 1ns/10ps
`default_nettype none
interface aldp_dec_if;
    import aldp_pkg::*;
    aldp_op_t     op;
    logic         lit_form;
    logic         hold;
    logic         cin_sel;
    logic [4:0]   dst;
    logic [4:0]   src_a;
    logic [4:0]   src_b;
    logic [15:0]  lit;
    modport dec (output op, lit_form, hold, cin_sel, dst, src_a, src_b, lit);
    modport dp  (input  op, lit_form, hold, cin_sel, dst, src_a, src_b, lit);
endinterface : aldp_dec_if
`default_nettype wire

// ---- src/aldp_decode.sv ----
// Instruction decoder: splits a 32-bit word into fields and an operation.
// Assumes the word is valid in the cycle it is presented; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module aldp_decode
    import aldp_pkg::*;
(
    input  wire logic [31:0] instr,
    aldp_dec_if.dec          d
);

    // Maps big-endian bit n to little-endian index.
    function automatic int be(input int n);
        return DATA_W - 1 - n;
    endfunction : be

    logic [5:0] opc;

    always_comb
    begin
        opc        = instr[be(0) -: OPC_W];
        d.dst      = instr[be(POS_DST)   -: REG_IDX_W];
        d.src_a    = instr[be(POS_SRC_A) -: REG_IDX_W];
        d.src_b    = instr[be(POS_SRC_B) -: REG_IDX_W];
        d.lit      = instr[LIT_W-1:0];
        d.lit_form = opc[3];
        d.hold     = instr[be(POS_HOLD)];
        d.cin_sel  = instr[be(POS_CIN)];
        if (opc == OPC_UPPER_LIT)
            d.op = ALDP_OP_UPPER;
        else if (opc[5:4] == OPC_CLASS_ADD && opc[0] == 1'b0)
            d.op = ALDP_OP_ADD;
        else if (opc[5:4] == OPC_CLASS_LOGIC && opc[2:0] == 3'h1)
            d.op = ALDP_OP_AND;
        else if (opc[5:4] == OPC_CLASS_LOGIC && opc[2:0] == 3'h3)
            d.op = ALDP_OP_ANDN;
        else
            d.op = ALDP_OP_NONE;
    end

endmodule : aldp_decode
`default_nettype wire

// ---- src/aldp_core.sv ----
// Add and logic datapath: register file, carry flag, upper-literal prefix.
// Assumes one instruction per enabled clock on instr with instr_valid high.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Register format: fields at bits 6,11,16
// - Literal format: sixteen-bit low literal field
// - Register add writes source sum
// - Hold bit keeps carry, else carry-out
// - Carry-in bit adds stored carry flag
// - Variants select hold and carry-in bits
// - Literal add uses sign-extended literal
// - Option bit differs from stored carry
// - Register AND writes bitwise AND
// - Literal AND uses sign-extended literal
// - AND-NOT complements second source
// - Literal AND-NOT complements extended literal
// - Prefix replaces upper literal half
module aldp_core
    import aldp_pkg::*;
#(
    parameter int NUM_REGS = 32
)
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic [4:0]  rd_addr,
    output logic      [31:0] rd_data,
    output logic             carry_flag,
    output logic             wr_en,
    output logic      [4:0]  wr_addr,
    output logic      [31:0] wr_data
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    aldp_dec_if dec_bus ();

    aldp_decode u_decode
    (
        .instr (instr),
        .d     (dec_bus)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] regs_ff [NUM_REGS];
    logic [31:0] nxt_regs [NUM_REGS];
    logic        carry_ff;
    logic        nxt_carry;
    logic        upper_vld_ff;
    logic        nxt_upper_vld;
    logic [15:0] upper_ff;
    logic [15:0] nxt_upper;
    logic        wr_en_ff;
    logic        nxt_wr_en;
    logic [4:0]  wr_addr_ff;
    logic [4:0]  nxt_wr_addr;
    logic [31:0] wr_data_ff;
    logic [31:0] nxt_wr_data;
    logic [31:0] rd_data_ff;
    logic [31:0] nxt_rd_data;

    // ------------------------------------------------------------------
    // Operand selection and execution
    // ------------------------------------------------------------------
    logic [31:0] first_src_reg;
    logic [31:0] second_src_reg;
    logic [31:0] literal;
    logic [31:0] operand_b;
    logic [32:0] sum;
    logic [31:0] result;
    logic        write_dst;
    logic        cin;

    always_comb
    begin
        first_src_reg  = regs_ff[dec_bus.src_a];
        second_src_reg = regs_ff[dec_bus.src_b];
        if (upper_vld_ff)
            literal = {upper_ff, dec_bus.lit};
        else
            literal = {{(DATA_W-LIT_W){dec_bus.lit[LIT_W-1]}}, dec_bus.lit};
        operand_b = dec_bus.lit_form ? literal : second_src_reg;
        cin       = dec_bus.cin_sel & carry_ff;
        sum       = {1'b0, first_src_reg} + {1'b0, operand_b} + {32'h0000_0000, cin};
        write_dst = 1'b1;
        case (dec_bus.op)
            ALDP_OP_ADD:  result = sum[31:0];
            ALDP_OP_AND:  result = first_src_reg & operand_b;
            ALDP_OP_ANDN: result = first_src_reg & ~operand_b;
            default:
            begin
                result    = RST_WORD;
                write_dst = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_regs = regs_ff;
        if (instr_valid && write_dst)
            nxt_regs[dec_bus.dst] = result;
    end

    // Reset acts only on enabled edges, since clk_en freezes all state.
    always_ff @(posedge mclk)
    begin
        if (clk_en)
        begin
            if (reset)
            begin
                for (int i = 0; i < NUM_REGS; i++)
                    regs_ff[i] <= RST_WORD;
            end
            else
            begin
                regs_ff <= nxt_regs;
            end
        end
    end

    // ------------------------------------------------------------------
    // Carry flag
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_carry = carry_ff;
        if (instr_valid && dec_bus.op == ALDP_OP_ADD && !dec_bus.hold)
            nxt_carry = sum[DATA_W];
    end

    always_ff @(posedge mclk)
    begin
        if (clk_en)
        begin
            if (reset)
                carry_ff <= RST_CARRY;
            else
                carry_ff <= nxt_carry;
        end
    end

    // ------------------------------------------------------------------
    // Upper literal prefix
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_upper     = upper_ff;
        nxt_upper_vld = upper_vld_ff;
        if (instr_valid)
        begin
            // The prefix covers only the instruction right after it.
            nxt_upper_vld = (dec_bus.op == ALDP_OP_UPPER);
            if (dec_bus.op == ALDP_OP_UPPER)
                nxt_upper = dec_bus.lit;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clk_en)
        begin
            if (reset)
            begin
                upper_ff     <= RST_UPPER;
                upper_vld_ff <= 1'b0;
            end
            else
            begin
                upper_ff     <= nxt_upper;
                upper_vld_ff <= nxt_upper_vld;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write and read ports
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_wr_en   = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        // The debug port shows the file as it stood before this edge.
        nxt_rd_data = regs_ff[rd_addr];
        if (instr_valid && write_dst)
        begin
            nxt_wr_en   = 1'b1;
            nxt_wr_addr = dec_bus.dst;
            nxt_wr_data = result;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (clk_en)
        begin
            if (reset)
            begin
                wr_en_ff   <= 1'b0;
                wr_addr_ff <= 5'h00;
                wr_data_ff <= RST_WORD;
                rd_data_ff <= RST_WORD;
            end
            else
            begin
                wr_en_ff   <= nxt_wr_en;
                wr_addr_ff <= nxt_wr_addr;
                wr_data_ff <= nxt_wr_data;
                rd_data_ff <= nxt_rd_data;
            end
        end
    end

    assign rd_data    = rd_data_ff;
    assign carry_flag = carry_ff;
    assign wr_en      = wr_en_ff;
    assign wr_addr    = wr_addr_ff;
    assign wr_data    = wr_data_ff;

endmodule : aldp_core
`default_nettype wire

// ---- verification/aldp_props.sv ----
// Port checker for aldp_core.
// Assumes it is bound to aldp_core and that clk_en is high during reset.
`timescale 1ns/10ps
`default_nettype none
module aldp_props
    import aldp_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic        instr_valid,
    input wire logic [31:0] instr,
    input wire logic        carry_flag,
    input wire logic        wr_en,
    input wire logic [4:0]  wr_addr,
    input wire logic [31:0] wr_data
);
    logic       pfx_ff;
    wire logic  ex = clk_en && !reset && instr_valid;
    wire logic  [5:0] opc = instr[31:26];
    wire logic  is_add = ex && opc[5:4] == 2'h0 && !opc[0];
    wire logic  is_lg = ex && opc inside {6'h21, 6'h23, 6'h29, 6'h2B};
    wire logic  no_pfx = !pfx_ff && instr[15:0] == {16{opc[1]}};
    // Remembers whether the last executed word was an upper-literal prefix.
    always_ff @(posedge mclk)
        if (clk_en)
            pfx_ff <= !reset && (instr_valid ? opc == OPC_UPPER_LIT : pfx_ff);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_exec; is_add || is_lg; endsequence
    sequence s_hold; is_add && instr[28]; endsequence
    sequence s_lit_edge; is_lg && opc[3] && no_pfx; endsequence
    property p_wr; s_exec |=> wr_en; endproperty
    a_wr: assert property (p_wr) else $error("no write pulse");
    property p_dst; s_exec |=> wr_addr == $past(instr[25:21]); endproperty
    a_dst: assert property (p_dst) else $error("wrong destination");
    property p_idle; clk_en && !instr_valid |=> !wr_en; endproperty
    a_idle: assert property (p_idle) else $error("write without instruction");
    property p_hold; s_hold |=> $stable(carry_flag); endproperty
    a_hold: assert property (p_hold) else $error("carry moved under hold");
    property p_lg; is_lg |=> $stable(carry_flag); endproperty
    a_lg: assert property (p_lg) else $error("logic op moved carry");
    property p_frz; !clk_en |=> $stable(wr_en) && $stable(wr_data); endproperty
    a_frz: assert property (p_frz) else $error("state moved with clk_en low");
    property p_lit; s_lit_edge |=> wr_data == 32'h0; endproperty
    a_lit: assert property (p_lit) else $error("literal logic edge wrong");
    property p_frzc; !clk_en |=> $stable(carry_flag); endproperty
    a_frzc: assert property (p_frzc) else $error("carry moved with clk_en low");
endmodule : aldp_props
bind aldp_core aldp_props i_aldp_props (.mclk(mclk), .reset(reset), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .carry_flag(carry_flag), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data));
`default_nettype wire

// ---- verification/test_aldp_core.sv ----
// Self-checking bench for aldp_core.
// Assumes the checker file is compiled with it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_aldp_core;
    import aldp_pkg::*;
    logic        mclk = 0, reset = 1, clk_en = 1, instr_valid = 0, cy = 0;
    logic [31:0] instr = 32'h0, rd_data, wr_data;
    logic [4:0]  rd_addr = 5'h0, wr_addr;
    logic        carry_flag, wr_en;
    int          n_mismatch = 0, cmp_count = 0;
    aldp_core i_aldp_core (.mclk(mclk), .reset(reset), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr(instr), .rd_addr(rd_addr), .rd_data(rd_data),
        .carry_flag(carry_flag), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    initial forever #50 mclk = ~mclk;
    function automatic logic [31:0] fa(logic [5:0] o, logic [4:0] d, a, b);
        return {o, d, a, b, 11'h0};
    endfunction : fa
    function automatic logic [31:0] fb(logic [5:0] o, logic [4:0] d, a, logic [15:0] k);
        return {o, d, a, k};
    endfunction : fb
    // Executes one word with a gap after it; cy holds the carry expected afterwards.
    task automatic run(logic [31:0] w, logic we, logic [31:0] d);
        @(posedge mclk);
        instr <= w;
        instr_valid <= 1'h1;
        @(posedge mclk);
        instr_valid <= 1'h0;
        #1;
        `CHK("wr_en", we, wr_en)
        if (we)
        begin
            `CHK("wr_addr", w[25:21], wr_addr)
            `CHK("wr_data", d, wr_data)
        end
        `CHK("carry", cy, carry_flag)
    endtask : run
    task automatic load(logic [4:0] r, logic [31:0] v);
        run({OPC_UPPER_LIT, 10'h0, v[31:16]}, 1'h0, 32'h0);
        run(fb(6'h0C, r, 5'h0, v[15:0]), 1'h1, v);
    endtask : load
    task automatic t_add;
        load(5'h1, 32'hFFFF_FFFF);
        load(5'h2, 32'h1);
        cy = 1'h1;
        run(fa(6'h00, 5'h3, 5'h1, 5'h2), 1'h1, 32'h0);
        run(fa(6'h06, 5'h6, 5'h2, 5'h2), 1'h1, 32'h3);
        run(fa(6'h04, 5'h4, 5'h2, 5'h2), 1'h1, 32'h2);
        cy = 1'h0;
        run(fa(6'h02, 5'h5, 5'h2, 5'h2), 1'h1, 32'h3);
        // An opcode outside the decoded set writes nothing and keeps carry.
        run(fa(6'h3F, 5'h7, 5'h2, 5'h2), 1'h0, 32'h0);
        $display("t_add done");
    endtask : t_add
    task automatic t_lit;
        run(fb(6'h0A, 5'h9, 5'h2, 16'h0001), 1'h1, 32'h2);
        cy = 1'h1;
        run(fb(6'h08, 5'h8, 5'h2, 16'hFFFF), 1'h1, 32'h0);
        run(fb(6'h0E, 5'h7, 5'h2, 16'h0002), 1'h1, 32'h4);
        run({OPC_UPPER_LIT, 10'h0, 16'h1234}, 1'h0, 32'h0);
        run(fb(6'h29, 5'hE, 5'h1, 16'h00FF), 1'h1, 32'h1234_00FF);
        run(fb(6'h29, 5'hF, 5'h1, 16'h8000), 1'h1, 32'hFFFF_8000);
        $display("t_lit done");
    endtask : t_lit
    task automatic t_logic;
        load(5'hA, 32'hF0F0_5A5A);
        load(5'hD, 32'h3C3C_00FF);
        run(fa(6'h21, 5'hB, 5'hA, 5'hD), 1'h1, 32'h3030_005A);
        run(fa(6'h23, 5'hB, 5'hA, 5'hD), 1'h1, 32'hC0C0_5A00);
        run(fb(6'h29, 5'hB, 5'hA, 16'h8001), 1'h1, 32'hF0F0_0000);
        run(fb(6'h2B, 5'hB, 5'hA, 16'h8001), 1'h1, 32'h0000_5A5A);
        run(fb(6'h29, 5'hB, 5'hA, 16'h0000), 1'h1, 32'h0);
        run(fb(6'h2B, 5'hB, 5'hA, 16'hFFFF), 1'h1, 32'h0);
        $display("t_logic done");
    endtask : t_logic
    task automatic t_b2b;
        @(posedge mclk);
        instr <= fa(6'h04, 5'h10, 5'h2, 5'h2);
        instr_valid <= 1'h1;
        rd_addr <= 5'h11;
        @(posedge mclk);
        instr <= fa(6'h04, 5'h11, 5'h10, 5'h10);
        #1;
        `CHK("first", 32'h2, wr_data)
        @(posedge mclk);
        instr_valid <= 1'h0;
        #1;
        `CHK("second", 32'h4, wr_data)
        repeat (2) @(posedge mclk);
        clk_en <= 1'h0;
        instr <= fa(6'h00, 5'h11, 5'h2, 5'h2);
        instr_valid <= 1'h1;
        #1;
        `CHK("readback", 32'h4, rd_data)
        repeat (2) @(posedge mclk);
        instr_valid <= 1'h0;
        clk_en <= 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        `CHK("frozen", 32'h4, rd_data)
        $display("t_b2b done");
    endtask : t_b2b
    // Resets in mid-run, then executes at the first edge after release.
    task automatic t_rst;
        @(posedge mclk);
        reset <= 1'h1;
        rd_addr <= 5'h1;
        @(posedge mclk);
        reset <= 1'h0;
        instr <= fb(6'h08, 5'h7, 5'h0, 16'h0005);
        instr_valid <= 1'h1;
        #1;
        `CHK("rst_data", 32'h0, wr_data)
        `CHK("rst_addr", 5'h0, wr_addr)
        `CHK("rst_carry", 1'h0, carry_flag)
        @(posedge mclk);
        instr_valid <= 1'h0;
        cy = 1'h0;
        #1;
        `CHK("post_rst_wr", 1'h1, wr_en)
        `CHK("post_rst_data", 32'h5, wr_data)
        `CHK("rst_regs", 32'h0, rd_data)
        `CHK("post_rst_carry", cy, carry_flag)
        $display("t_rst done");
    endtask : t_rst
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (20) @(posedge mclk);
        reset <= 1'h0;
        t_add;
        t_lit;
        t_logic;
        t_b2b;
        t_rst;
        report_and_stop;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        report_and_stop;
    end
endmodule : test_aldp_core
`default_nettype wire
